// file: inc/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

	// ********************************
	// bus and data widths
	// ********************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int RES_W  = 10;
	localparam int CH_W   = 5;
	localparam int CNT_W  = 8;
	localparam int IRQ_W  = 2;

	// ********************************
	// register byte offsets
	// ********************************
	localparam logic [ADDR_W-1:0] OFF_SC1      = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_RESULT   = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CFG      = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_CMP      = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STS  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h14;

	// ********************************
	// field positions
	// ********************************
	localparam int FLAG_BIT  = 7;
	localparam int IRQEN_BIT = 6;
	localparam int CONT_BIT  = 5;
	localparam int HWT_BIT   = 0;
	localparam int CMPEN_BIT = 1;
	localparam int CMPGT_BIT = 2;
	localparam int EV_DONE   = 0;
	localparam int EV_OVR    = 1;
	localparam int CH_GAP_BIT = 3;

	// ********************************
	// codes and reset values
	// ********************************
	localparam logic [CH_W-1:0]  CH_OFF      = 5'h1F;
	localparam logic [CH_W-1:0]  CH_RST      = 5'h1F;
	localparam logic [RES_W-1:0] CMP_RST     = 10'h000;
	localparam logic [IRQ_W-1:0] MASK_RST    = 2'h0;
	localparam logic [1:0]       RESP_OKAY   = 2'h0;
	localparam logic [1:0]       RESP_SLVERR = 2'h2;

	// ********************************
	// timing
	// ********************************
	localparam int CLK_PERIOD_NS  = 20;
	localparam int SAMPLE_TIME_NS = 200;
	localparam int SETTLE_TIME_NS = 100;
	localparam int SAMPLE_CYC     = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_CYC     = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_OFF  = 3'b001,
		ST_IDLE = 3'b010,
		ST_CONV = 3'b100
	} conv_state_t;

endpackage : adc_ctrl_pkg

// file: design/sar_sequencer.sv
`timescale 1ns/1ps
module sar_sequencer #(
	parameter int RES_W      = 10,
	parameter int SAMPLE_CYC = 10,
	parameter int SETTLE_CYC = 5
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	// control
	input  wire logic             start,
	input  wire logic             abort,
	input  wire logic             comp_hi,
	// status and analog drive
	output logic                  busy,
	output logic                  sample_track,
	output logic                  done,
	output logic [RES_W-1:0]      result,
	output logic [RES_W-1:0]      dac_code
);
	import adc_ctrl_pkg::*;

	logic                busy_q, busy_d;
	logic                samp_q, samp_d;
	logic                done_q, done_d;
	logic [CNT_W-1:0]    cnt_q, cnt_d;
	logic [RES_W-1:0]    trial_q, trial_d;
	logic [RES_W-1:0]    code_q, code_d;
	logic [RES_W-1:0]    res_q, res_d;
	logic [RES_W-1:0]    keep;

	// sample phase, then one trial bit per settle window, msb first
	always_comb begin
		busy_d  = busy_q;
		samp_d  = samp_q;
		done_d  = 1'b0;
		cnt_d   = cnt_q;
		trial_d = trial_q;
		code_d  = code_q;
		res_d   = res_q;
		keep    = comp_hi ? code_q : (code_q & ~trial_q);
		if (start) begin
			busy_d  = 1'b1;
			samp_d  = 1'b1;
			cnt_d   = CNT_W'(SAMPLE_CYC - 1);
			trial_d = '0;
			code_d  = '0;
		end else if (abort) begin
			busy_d = 1'b0;
			samp_d = 1'b0;
			code_d = '0;
		end else if (busy_q) begin
			if (cnt_q != '0) begin
				cnt_d = cnt_q - 1'b1;
			end else if (samp_q) begin
				samp_d  = 1'b0;
				trial_d = {1'b1, {(RES_W-1){1'b0}}};
				code_d  = {1'b1, {(RES_W-1){1'b0}}};
				cnt_d   = CNT_W'(SETTLE_CYC - 1);
			end else if (trial_q[0]) begin
				busy_d = 1'b0;
				done_d = 1'b1;
				res_d  = keep;
				code_d = '0;
			end else begin
				trial_d = trial_q >> 1;
				code_d  = keep | (trial_q >> 1);
				cnt_d   = CNT_W'(SETTLE_CYC - 1);
			end
		end
	end

	// state registers
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			busy_q  <= 1'b0;
			samp_q  <= 1'b0;
			done_q  <= 1'b0;
			cnt_q   <= '0;
			trial_q <= '0;
			code_q  <= '0;
			res_q   <= '0;
		end else begin
			busy_q  <= busy_d;
			samp_q  <= samp_d;
			done_q  <= done_d;
			cnt_q   <= cnt_d;
			trial_q <= trial_d;
			code_q  <= code_d;
			res_q   <= res_d;
		end
	end

	assign busy         = busy_q;
	assign sample_track = samp_q;
	assign done         = done_q;
	assign result       = res_q;
	assign dac_code     = code_q;

endmodule : sar_sequencer

// file: design/adc_status_control.sv
`timescale 1ns/1ps
// How it works
// - compare off: done flag bit 7 sets at every conversion end.
// - compare on: flag sets only when compare true, else unchanged.
// - writing control register or reading result clears the done flag.
// - flag setting with irq enable bit 6 high raises the interrupt when irq mask bit 0 is set.
// - continuous bit 5 low: one conversion per software write or hardware trigger.
// - continuous bit 5 high: back-to-back conversions after write or trigger.
// - five-bit channel field bits 4:0 selects analog input n; codes with bit 3 set leave the mux open.
// - all-ones channel code powers converter off and isolates the input.
// - writing all ones stops continuous mode with no extra conversion.
// - single mode enters low power by itself when a conversion completes.
module adc_status_control (
	// clock and reset
	input  wire logic                               ref_clk,
	input  wire logic                               reset_n,
	// axi4-lite write address and data
	input  wire logic                               s_axi_awvalid,
	output logic                                    s_axi_awready,
	input  wire logic [adc_ctrl_pkg::ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                               s_axi_wvalid,
	output logic                                    s_axi_wready,
	input  wire logic [adc_ctrl_pkg::DATA_W-1:0]    s_axi_wdata,
	input  wire logic [3:0]                         s_axi_wstrb,
	// axi4-lite write response
	output logic                                    s_axi_bvalid,
	input  wire logic                               s_axi_bready,
	output logic [1:0]                              s_axi_bresp,
	// axi4-lite read
	input  wire logic                               s_axi_arvalid,
	output logic                                    s_axi_arready,
	input  wire logic [adc_ctrl_pkg::ADDR_W-1:0]    s_axi_araddr,
	output logic                                    s_axi_rvalid,
	input  wire logic                               s_axi_rready,
	output logic [adc_ctrl_pkg::DATA_W-1:0]         s_axi_rdata,
	output logic [1:0]                              s_axi_rresp,
	// analog front end
	input  wire logic                               hw_trigger_event,
	input  wire logic                               comp_in,
	output logic [adc_ctrl_pkg::CH_W-1:0]           chan_sel,
	output logic                                    mux_connect,
	output logic                                    conv_power,
	output logic                                    sample_track,
	output logic [adc_ctrl_pkg::RES_W-1:0]          dac_code,
	// interrupt
	output logic                                    irq
);
	import adc_ctrl_pkg::*;

	// ********************************
	// declarations
	// ********************************
	logic                aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [ADDR_W-1:0]   aw_addr_q, aw_addr_d;
	logic [7:0]          w_data_q, w_data_d;
	logic                w_lane_q, w_lane_d;
	logic                bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]          bresp_q, bresp_d, rresp_q, rresp_d;
	logic [DATA_W-1:0]   rdata_q, rdata_d;
	logic                flag_q, flag_d, irq_en_q, irq_en_d, cont_q, cont_d;
	logic [CH_W-1:0]     ch_q, ch_d;
	logic                hw_mode_q, hw_mode_d, cmp_en_q, cmp_en_d, cmp_gt_q, cmp_gt_d;
	logic [RES_W-1:0]    cmp_val_q, cmp_val_d, result_q, result_d;
	logic [IRQ_W-1:0]    irq_sts_q, irq_sts_d, irq_mask_q, irq_mask_d, events;
	conv_state_t         state_q, state_d;
	logic                power_q, power_d, connect_q, connect_d;
	logic                trig_s1_q, trig_s2_q, trig_s3_q, comp_s1_q, comp_s2_q;
	logic                wr_fire, wr_map, lane_wr, sc1_wr, rd_fire, res_rd, hw_edge;
	logic                sar_start, sar_abort, sar_busy, sar_done, cmp_true, set_flag;
	logic [RES_W-1:0]    sar_result;

	// ********************************
	// bus decode
	// ********************************
	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready  = !w_have_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
	assign wr_map  = aw_addr_q inside {OFF_SC1, OFF_RESULT, OFF_CFG, OFF_CMP, OFF_IRQ_STS, OFF_IRQ_MASK};
	assign lane_wr = wr_fire && w_lane_q;
	assign sc1_wr  = lane_wr && (aw_addr_q == OFF_SC1);
	assign rd_fire = s_axi_arvalid && !rvalid_q;
	assign res_rd  = rd_fire && (s_axi_araddr == OFF_RESULT);
	assign hw_edge = trig_s2_q && !trig_s3_q;

	// compare against threshold, then gate the flag
	assign cmp_true = cmp_gt_q ? (sar_result >= cmp_val_q) : (sar_result < cmp_val_q);
	assign set_flag = sar_done && (!cmp_en_q || cmp_true);
	assign events[EV_DONE] = set_flag && irq_en_q;
	assign events[EV_OVR]  = set_flag && flag_q && !(sc1_wr || res_rd);

	// ********************************
	// next-state logic
	// ********************************
	always_comb begin
		aw_have_d = aw_have_q;
		aw_addr_d = aw_addr_q;
		w_have_d  = w_have_q;
		w_data_d  = w_data_q;
		w_lane_d  = w_lane_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rresp_d   = rresp_q;
		rdata_d   = rdata_q;
		irq_en_d  = irq_en_q;
		cont_d    = cont_q;
		ch_d      = ch_q;
		hw_mode_d = hw_mode_q;
		cmp_en_d  = cmp_en_q;
		cmp_gt_d  = cmp_gt_q;
		cmp_val_d = cmp_val_q;
		irq_mask_d = irq_mask_q;
		irq_sts_d = irq_sts_q;
		result_d  = set_flag ? sar_result : result_q;
		state_d   = state_q;
		sar_start = 1'b0;
		sar_abort = 1'b0;
		// write channel capture, either order
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_d = 1'b1;
			w_data_d = s_axi_wdata[7:0];
			w_lane_d = s_axi_wstrb[0];
		end
		if (wr_fire) begin
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = wr_map ? RESP_OKAY : RESP_SLVERR;
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		// register writes
		if (lane_wr) begin
			unique case (aw_addr_q)
				OFF_SC1: begin
					irq_en_d = w_data_q[IRQEN_BIT];
					cont_d   = w_data_q[CONT_BIT];
					ch_d     = w_data_q[CH_W-1:0];
				end
				OFF_CFG: begin
					hw_mode_d = w_data_q[HWT_BIT];
					cmp_en_d  = w_data_q[CMPEN_BIT];
					cmp_gt_d  = w_data_q[CMPGT_BIT];
				end
				OFF_CMP:      cmp_val_d = {2'h0, w_data_q};
				OFF_IRQ_STS:  irq_sts_d = irq_sts_q & ~w_data_q[IRQ_W-1:0];
				OFF_IRQ_MASK: irq_mask_d = w_data_q[IRQ_W-1:0];
				default: ;
			endcase
		end
		irq_sts_d = irq_sts_d | events;
		// read channel
		if (rd_fire) begin
			rvalid_d = 1'b1;
			rresp_d  = RESP_OKAY;
			unique case (s_axi_araddr)
				OFF_SC1:      rdata_d = {24'h0, flag_q, irq_en_q, cont_q, ch_q};
				OFF_RESULT:   rdata_d = {22'h0, result_q};
				OFF_CFG:      rdata_d = {29'h0, cmp_gt_q, cmp_en_q, hw_mode_q};
				OFF_CMP:      rdata_d = {22'h0, cmp_val_q};
				OFF_IRQ_STS:  rdata_d = {30'h0, irq_sts_q};
				OFF_IRQ_MASK: rdata_d = {30'h0, irq_mask_q};
				default: begin
					rdata_d = 32'h0;
					rresp_d = RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		// conversion sequencing
		if (sc1_wr) begin
			sar_abort = 1'b1;
			if (w_data_q[CH_W-1:0] == CH_OFF) begin
				state_d = ST_OFF;
			end else if (!hw_mode_q) begin
				sar_start = 1'b1;
				state_d   = ST_CONV;
			end else begin
				state_d = ST_IDLE;
			end
		end else if (hw_edge && hw_mode_q && (state_q == ST_IDLE)) begin
			sar_start = 1'b1;
			state_d   = ST_CONV;
		end else if (sar_done && (state_q == ST_CONV)) begin
			if (cont_q) begin
				sar_start = 1'b1;
			end else begin
				state_d = ST_IDLE;
			end
		end
	end

	// done flag: a completion beats a same-cycle clear
	always_comb begin
		if (set_flag) begin
			flag_d = 1'b1;
		end else if (sc1_wr || res_rd) begin
			flag_d = 1'b0;
		end else begin
			flag_d = flag_q;
		end
	end

	// analog drive: reserved codes convert with the mux open
	assign power_d   = (state_d == ST_CONV);
	assign connect_d = (state_d == ST_CONV) && !ch_d[CH_GAP_BIT];

	// ********************************
	// registers
	// ********************************
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= '0;
			w_have_q  <= 1'b0;
			w_data_q  <= 8'h00;
			w_lane_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			rvalid_q  <= 1'b0;
			rresp_q   <= RESP_OKAY;
			rdata_q   <= 32'h0;
			flag_q    <= 1'b0;
			irq_en_q  <= 1'b0;
			cont_q    <= 1'b0;
			ch_q      <= CH_RST;
			hw_mode_q <= 1'b0;
			cmp_en_q  <= 1'b0;
			cmp_gt_q  <= 1'b0;
			cmp_val_q <= CMP_RST;
			result_q  <= '0;
			irq_sts_q <= '0;
			irq_mask_q <= MASK_RST;
			state_q   <= ST_OFF;
			power_q   <= 1'b0;
			connect_q <= 1'b0;
			trig_s1_q <= 1'b0;
			trig_s2_q <= 1'b0;
			trig_s3_q <= 1'b0;
			comp_s1_q <= 1'b0;
			comp_s2_q <= 1'b0;
		end else begin
			aw_have_q <= aw_have_d;
			aw_addr_q <= aw_addr_d;
			w_have_q  <= w_have_d;
			w_data_q  <= w_data_d;
			w_lane_q  <= w_lane_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rresp_q   <= rresp_d;
			rdata_q   <= rdata_d;
			flag_q    <= flag_d;
			irq_en_q  <= irq_en_d;
			cont_q    <= cont_d;
			ch_q      <= ch_d;
			hw_mode_q <= hw_mode_d;
			cmp_en_q  <= cmp_en_d;
			cmp_gt_q  <= cmp_gt_d;
			cmp_val_q <= cmp_val_d;
			result_q  <= result_d;
			irq_sts_q <= irq_sts_d;
			irq_mask_q <= irq_mask_d;
			state_q   <= state_d;
			power_q   <= power_d;
			connect_q <= connect_d;
			trig_s1_q <= hw_trigger_event;
			trig_s2_q <= trig_s1_q;
			trig_s3_q <= trig_s2_q;
			comp_s1_q <= comp_in;
			comp_s2_q <= comp_s1_q;
		end
	end

	// successive approximation engine
	sar_sequencer #(
		.RES_W      (RES_W),
		.SAMPLE_CYC (SAMPLE_CYC),
		.SETTLE_CYC (SETTLE_CYC)
	) i_sar_sequencer (
		.ref_clk      (ref_clk),
		.reset_n      (reset_n),
		.start        (sar_start),
		.abort        (sar_abort),
		.comp_hi      (comp_s2_q),
		.busy         (sar_busy),
		.sample_track (sample_track),
		.done         (sar_done),
		.result       (sar_result),
		.dac_code     (dac_code)
	);

	// outputs
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp  = rresp_q;
	assign s_axi_rdata  = rdata_q;
	assign chan_sel     = ch_q;
	assign mux_connect  = connect_q;
	assign conv_power   = power_q;
	assign irq          = |(irq_sts_q & irq_mask_q);

	// ********************************
	// checks
	// ********************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	a_flag_on_done: assert property (sar_done && !cmp_en_q |=> flag_q)
		else $error("done flag missed a completion");
	a_compare_gate: assert property (sar_done && cmp_en_q && !cmp_true && !flag_q |=> !flag_q)
		else $error("flag set on false compare");
	a_write_clears: assert property ((sc1_wr || res_rd) && !sar_done |=> !flag_q)
		else $error("flag not cleared by access");
	a_irq_enabled: assert property ($rose(irq_sts_q[EV_DONE]) |-> $past(irq_en_q) && $past(sar_done))
		else $error("done interrupt without enable");
	a_single_stop: assert property (sar_done && !cont_q && state_q == ST_CONV && !sc1_wr
		|=> state_q == ST_IDLE && !sar_busy)
		else $error("single conversion restarted");
	a_cont_restart: assert property (sar_done && cont_q && state_q == ST_CONV && !sc1_wr
		|=> sar_busy && sample_track)
		else $error("continuous mode did not restart");
	a_chan_drive: assert property (mux_connect |-> conv_power && chan_sel != CH_OFF && !chan_sel[CH_GAP_BIT])
		else $error("mux drives wrong channel");
	a_off_isolates: assert property (state_q == ST_OFF |-> !conv_power && !mux_connect)
		else $error("off code left converter live");
	a_stop_no_extra: assert property (sc1_wr && w_data_q[CH_W-1:0] == CH_OFF |=> !sar_busy [*3])
		else $error("extra conversion after stop");
	a_low_power: assert property (sar_done && !cont_q && state_q == ST_CONV && !sc1_wr
		|=> !conv_power)
		else $error("no low power after single conversion");
	a_reserved_open: assert property (ch_q[CH_GAP_BIT] |=> !mux_connect || !ch_q[CH_GAP_BIT])
		else $error("reserved code connected an input");

endmodule : adc_status_control

// file: test/analog_src_model.sv
`timescale 1ns/1ps
module analog_src_model (
	// clock
	input  wire logic                          ref_clk,
	// converter side
	input  wire logic [adc_ctrl_pkg::CH_W-1:0]  chan_sel,
	input  wire logic                          mux_connect,
	input  wire logic [adc_ctrl_pkg::RES_W-1:0] dac_code,
	// comparator answer
	output logic                               comp_in
);
	import adc_ctrl_pkg::*;
	logic [RES_W-1:0] level;
	logic             junk_q;
	// each input n sits at its own fixed level
	assign level = RES_W'(chan_sel) * 10'd40 + 10'd5;
	// an isolated input gives a comparator that flips every cycle, settling from unknown at the first edge
	always_ff @(posedge ref_clk) begin
		junk_q <= (junk_q !== 1'b1);
	end
	// comparator high when input at or above trial code
	assign comp_in = mux_connect ? (level >= dac_code) : junk_q;
endmodule : analog_src_model

// file: test/test_adc_status_control.sv
`timescale 1ns/1ps
module test_adc_status_control;
	import adc_ctrl_pkg::*;
	logic              ref_clk, reset_n, hw_trigger_event, comp_in;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp, rs;
	logic [CH_W-1:0]   chan_sel;
	logic [RES_W-1:0]  dac_code;
	logic              mux_connect, conv_power, sample_track, irq;
	int                failures = 0;
	int                n_tests = 0;

	// ********************************
	// design and analog inputs
	// ********************************
	adc_status_control i_adc_status_control (.ref_clk(ref_clk), .reset_n(reset_n),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .hw_trigger_event(hw_trigger_event),
		.comp_in(comp_in), .chan_sel(chan_sel), .mux_connect(mux_connect), .conv_power(conv_power),
		.sample_track(sample_track), .dac_code(dac_code), .irq(irq));
	analog_src_model i_analog_src_model (.ref_clk(ref_clk), .chan_sel(chan_sel),
		.mux_connect(mux_connect), .dac_code(dac_code), .comp_in(comp_in));

	// ********************************
	// helpers
	// ********************************
	function automatic logic [DATA_W-1:0] lvl(input int n);
		return DATA_W'(n * 40 + 5);
	endfunction : lvl
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp, input string msg);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check
	task automatic stop_test;
		if (failures == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	// one write, address and data offered together
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		bit pa, pw;
		@(posedge ref_clk);
		pa = 1;
		pw = 1;
		s_axi_awvalid <= 1'b1; s_axi_awaddr <= a; s_axi_wvalid <= 1'b1;
		s_axi_wdata <= d; s_axi_wstrb <= 4'hF; s_axi_bready <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (pa && s_axi_awready) begin pa = 0; s_axi_awvalid <= 1'b0; end
			if (pw && s_axi_wready) begin pw = 0; s_axi_wvalid <= 1'b0; end
			if (s_axi_bvalid) begin rs = s_axi_bresp; s_axi_bready <= 1'b0; break; end
		end
	endtask : wr
	task automatic rdr(input logic [ADDR_W-1:0] a);
		bit pa;
		@(posedge ref_clk);
		pa = 1;
		s_axi_arvalid <= 1'b1; s_axi_araddr <= a; s_axi_rready <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (pa && s_axi_arready) begin pa = 0; s_axi_arvalid <= 1'b0; end
			if (s_axi_rvalid) begin rd = s_axi_rdata; rs = s_axi_rresp; s_axi_rready <= 1'b0; break; end
		end
	endtask : rdr
	// poll the done flag under a bound
	task automatic wait_done;
		for (int k = 0; k < 100; k++) begin
			rdr(OFF_SC1);
			if (rd[FLAG_BIT] === 1'b1) break;
		end
		check(rd[FLAG_BIT], 1, "done flag");
	endtask : wait_done
	task automatic wait_idle;
		for (int k = 0; k < 300 && conv_power !== 1'b0; k++) @(posedge ref_clk);
		check(conv_power, 0, "power down");
	endtask : wait_idle
	task automatic pulse_trig;
		@(posedge ref_clk) hw_trigger_event <= 1'b1;
		repeat (4) @(posedge ref_clk);
		hw_trigger_event <= 1'b0;
	endtask : pulse_trig

	// ********************************
	// scenarios
	// ********************************
	task automatic t_reset;
		rdr(OFF_SC1);
		check(rd, 32'h0000001F, "control reset");
		check({conv_power, mux_connect, irq}, 0, "outputs after reset");
		rdr(OFF_CFG);
		check(rd, 0, "config reset");
		rdr(8'h18);
		check(rs, RESP_SLVERR, "unmapped read");
		wr(8'h18, 32'h000000FF);
		check(rs, RESP_SLVERR, "unmapped write");
	endtask : t_reset
	task automatic t_single;
		int chs[4] = '{0, 7, 16, 23};
		foreach (chs[i]) begin
			wr(OFF_SC1, DATA_W'(chs[i]));
			@(posedge ref_clk);
			check({chan_sel, mux_connect, conv_power}, {CH_W'(chs[i]), 2'b11}, "converting");
			check({sample_track, dac_code}, {1'b1, RES_W'(0)}, "sampling phase");
			wait_done;
			wait_idle;
			rdr(OFF_RESULT);
			check(rd, lvl(chs[i]), "result");
			rdr(OFF_SC1);
			check(rd[FLAG_BIT], 0, "cleared by result read");
		end
	endtask : t_single
	task automatic t_write_clear;
		wr(OFF_SC1, 32'h00000002);
		wait_done;
		wr(OFF_SC1, 32'h0000001F);
		check(rs, RESP_OKAY, "write response");
		rdr(OFF_SC1);
		check(rd, 32'h0000001F, "cleared by write");
		check({conv_power, mux_connect}, 0, "off code");
	endtask : t_write_clear
	task automatic t_irq;
		wr(OFF_IRQ_MASK, 32'h00000001);
		wr(OFF_SC1, 32'h00000002);
		wait_done;
		rdr(OFF_IRQ_STS);
		check({rd[0], irq}, 0, "no irq when disabled");
		wr(OFF_SC1, 32'h00000042);
		wait_done;
		rdr(OFF_IRQ_STS);
		check(rd, 32'h00000001, "irq status");
		check(irq, 1, "irq raised");
		wr(OFF_IRQ_STS, 32'h00000001);
		@(posedge ref_clk);
		check(irq, 0, "irq cleared");
		wr(OFF_SC1, 32'h0000001F);
	endtask : t_irq
	task automatic t_compare;
		logic [7:0] cfg[3] = '{8'h06, 8'h06, 8'h02};
		logic [7:0] cmp[3] = '{8'hC8, 8'h14, 8'hC8};
		logic       exp[3] = '{1'b0, 1'b1, 1'b1};
		for (int i = 0; i < 3; i++) begin
			wr(OFF_CFG, DATA_W'(cfg[i]));
			wr(OFF_CMP, DATA_W'(cmp[i]));
			wr(OFF_SC1, 32'h00000001);
			wait_idle;
			rdr(OFF_SC1);
			check(rd[FLAG_BIT], exp[i], "compare gating");
			if (exp[i]) begin
				rdr(OFF_RESULT);
				check(rd, lvl(1), "compare result");
			end
		end
		wr(OFF_CFG, 0);
	endtask : t_compare
	task automatic t_continuous;
		int hi = 0;
		wr(OFF_SC1, 32'h00000025);
		wait_done;
		rdr(OFF_RESULT);
		check(rd, lvl(5), "first continuous result");
		wait_done;
		wr(OFF_SC1, 32'h0000001F);
		repeat (120) begin
			@(posedge ref_clk);
			if (conv_power !== 1'b0) hi++;
		end
		check(hi, 0, "stopped by off code");
		rdr(OFF_SC1);
		check(rd, 32'h0000001F, "no extra conversion");
	endtask : t_continuous
	task automatic t_hwtrig;
		wr(OFF_CFG, 32'h00000001);
		wr(OFF_SC1, 32'h00000004);
		repeat (20) @(posedge ref_clk);
		check(conv_power, 0, "armed waits for trigger");
		for (int i = 0; i < 2; i++) begin
			pulse_trig;
			wait_done;
			wait_idle;
			rdr(OFF_RESULT);
			check(rd, lvl(4), "triggered result");
		end
		wr(OFF_SC1, 32'h00000024);
		pulse_trig;
		wait_done;
		rdr(OFF_RESULT);
		check(rd, lvl(4), "continuous triggered result");
		wait_done;
		wr(OFF_SC1, 32'h0000001F);
		wr(OFF_CFG, 0);
	endtask : t_hwtrig
	task automatic t_reserved;
		int hi = 0;
		wr(OFF_SC1, 32'h00000008);
		check(conv_power, 1, "reserved code converts");
		for (int k = 0; k < 300 && conv_power !== 1'b0; k++) begin
			@(posedge ref_clk);
			if (mux_connect !== 1'b0) hi++;
		end
		check(hi, 0, "reserved code isolated");
		wait_done;
		rdr(OFF_RESULT);
	endtask : t_reserved

	// ********************************
	// clock, reset, sequence, watchdog
	// ********************************
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial begin
		reset_n = 1'b0; hw_trigger_event = 1'b0;
		s_axi_awvalid = 1'b0; s_axi_awaddr = '0; s_axi_wvalid = 1'b0; s_axi_wdata = '0;
		s_axi_wstrb = 4'h0; s_axi_bready = 1'b0; s_axi_arvalid = 1'b0; s_axi_araddr = '0;
		s_axi_rready = 1'b0;
		repeat (12) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_reset;
		t_single;
		t_write_clear;
		t_irq;
		t_compare;
		t_continuous;
		t_hwtrig;
		t_reserved;
		stop_test;
	end
	initial begin
		repeat (30000) @(posedge ref_clk);
		failures++;
		stop_test;
	end
endmodule : test_adc_status_control
